// >>> core/phy_special_ctrl_intr_counters.sv
`timescale 1ns/100ps
// What this block does
// (RULE_01) scrambler and encoder bypass bits drive outputs
// (RULE_02) bit 13 forces H transmit pattern
// (RULE_03) bit 12 forces 34 transmit pattern
// (RULE_04) bit 11 forces good link on detect
// (RULE_05) host writes zero to reserved bits
// (RULE_06) bit 9 disables fast receive carrier sense
// (RULE_07) bit 7 loops back auto-negotiation
// (RULE_08) bit 6 tri-states line transmit drivers
// (RULE_09) bit 5 forces reversed receive polarity
// (RULE_10) bit 4 disables automatic polarity correction
// (RULE_11) bit 3 disables squelch test
// (RULE_12) bit 2 enables extended squelch
// (RULE_13) bits 1, 0 disable link check, jabber
// (RULE_14) interrupt line only when enable set
// (RULE_15) link status change sets status bit
// (RULE_16) reading interrupt register clears status bit
// (RULE_17) interrupt reserved bits read zero
// (RULE_18) false carrier counter counts bad delimiters
// (RULE_19) back to back false carriers count disconnect
// (RULE_20) both counters saturate at all ones
// (RULE_21) counter read clears that counter
// (RULE_22) counters and status zero after reset
module phy_special_ctrl_intr_counters
   import phy_regs_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic MDC,
   input wire logic MDIO_I,
   output logic MDIO_O,
   output logic MDIO_OE,
   input wire logic [4:0] PHY_ADDR,
   input wire logic LINK_STATUS,
   input wire logic FALSE_CARRIER,
   input wire logic GOOD_START_STREAM_DELIMITER,
   input wire logic SIGNAL_DETECT_IN,
   input wire logic FAST_RECEIVE_PATH_CRS_IN,
   output logic SCRAMBLER_BYPASS,
   output logic ENCODER_BYPASS,
   output logic FORCE_H_PATTERN,
   output logic FORCE_34_PATTERN,
   output logic SIGNAL_DETECT_OUTPUT,
   output logic FAST_RECEIVE_PATH_CRS,
   output logic AN_LOOPBACK,
   output logic TX_DRIVER_TRISTATE,
   output logic FORCE_REV_POLARITY,
   output logic AUTO_POLARITY_DISABLE,
   output logic SQUELCH_TEST_DISABLE,
   output logic EXT_SQUELCH_EN,
   output logic LINK_CHECK_DISABLE,
   output logic JABBER_DISABLE,
   output logic LINK_IRQ
);

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      mdio_state_e st;
      logic mdc_s1;
      logic mdc_s2;
      logic mdc_s3;
      logic mdio_s1;
      logic mdio_s2;
      logic [4:0] phy_s1;
      logic [4:0] phy_s2;
      logic [5:0] pre_cnt;
      logic [4:0] bit_cnt;
      logic [15:0] shift;
      logic op_read;
      logic [4:0] reg_addr;
      logic mdio_o;
      logic mdio_oe;
      logic [15:0] ctrl;
      logic int_en;
      logic link_chg;
      logic link_prev;
      logic primed;
      logic [15:0] fc;
      logic [15:0] dc;
      logic fc_run;
      logic dc_done;
      logic irq;
      logic sd_out;
      logic crs_out;
   } state_s;

   // all-zero also selects S_PRE and CTRL_RESET
   localparam state_s RESET_VAL = '0;

   state_s r;
   state_s n;

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == CNT_MAX) ? v : 16'(v + CNT_ONE);
   endfunction

   function automatic logic [15:0] read_word(input state_s s);
      unique case (s.reg_addr)
         REG_SPECIAL_CONTROL: return s.ctrl;
         REG_LINK_INTERRUPT: return {INT_RESERVED_READ, s.int_en, s.link_chg}; // RULE_17
         REG_FALSE_CARRIER_COUNT: return s.fc;
         REG_DISCONNECT_COUNT: return s.dc;
         default: return CNT_ZERO;
      endcase
   endfunction

   // ***************************************************
   // frame events
   // ***************************************************
   logic mdc_rise;
   logic mdio_s;
   logic rd_load;
   logic rd18;
   logic rd19;
   logic rd20;
   logic wr_done;
   logic [15:0] wr_data;
   logic link_change;
   logic dc_event;

   // both synchronisers have equal depth, so data lines up with the edge
   assign mdc_rise = r.mdc_s2 & ~r.mdc_s3;
   assign mdio_s = r.mdio_s2;
   assign rd_load = mdc_rise && (r.st == S_TA) && (r.bit_cnt == TA_SECOND) && r.op_read;
   assign rd18 = rd_load && (r.reg_addr == REG_LINK_INTERRUPT);
   assign rd19 = rd_load && (r.reg_addr == REG_FALSE_CARRIER_COUNT);
   assign rd20 = rd_load && (r.reg_addr == REG_DISCONNECT_COUNT);
   assign wr_done = mdc_rise && (r.st == S_WR) && (r.bit_cnt == DATA_LAST);
   assign wr_data = {r.shift[14:0], mdio_s};
   assign link_change = r.primed && (LINK_STATUS != r.link_prev);
   assign dc_event = FALSE_CARRIER && r.fc_run && !r.dc_done;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      logic [12:0] hdr;
      hdr = '0;
      n = r;
      n.mdc_s1 = MDC;
      n.mdc_s2 = r.mdc_s1;
      n.mdc_s3 = r.mdc_s2;
      n.mdio_s1 = MDIO_I;
      n.mdio_s2 = r.mdio_s1;
      n.phy_s1 = PHY_ADDR;
      n.phy_s2 = r.phy_s1;

      if (mdc_rise) begin
         unique case (r.st)
            S_PRE: begin
               if (mdio_s) begin
                  if (r.pre_cnt != PREAMBLE_BITS) begin
                     n.pre_cnt = 6'(r.pre_cnt + 6'h01);
                  end
               end else if (r.pre_cnt == PREAMBLE_BITS) begin
                  n.st = S_HDR;
                  n.bit_cnt = '0;
               end else begin
                  n.pre_cnt = '0;
               end
            end
            S_HDR: begin
               n.shift = wr_data;
               n.bit_cnt = 5'(r.bit_cnt + 5'h01);
               if (r.bit_cnt == HDR_LAST) begin
                  hdr = wr_data[12:0];
                  n.bit_cnt = '0;
                  n.pre_cnt = '0;
                  n.op_read = (hdr[HDR_OP_HI:HDR_OP_LO] == OP_READ);
                  n.reg_addr = hdr[HDR_REG_HI:HDR_REG_LO];
                  // frames for other ports or with bad codes wait for a new preamble
                  if (hdr[HDR_ST_BIT] && (hdr[HDR_PHY_HI:HDR_PHY_LO] == r.phy_s2) &&
                      ((hdr[HDR_OP_HI:HDR_OP_LO] == OP_READ) || (hdr[HDR_OP_HI:HDR_OP_LO] == OP_WRITE))) begin
                     n.st = S_TA;
                  end else begin
                     n.st = S_PRE;
                  end
               end
            end
            S_TA: begin
               if (r.bit_cnt != TA_SECOND) begin
                  n.bit_cnt = TA_SECOND;
                  if (r.op_read) begin
                     n.mdio_oe = 1'b1;
                     n.mdio_o = 1'b0;
                  end
               end else begin
                  n.bit_cnt = '0;
                  if (r.op_read) begin
                     n.shift = read_word(r);
                     n.mdio_o = n.shift[15];
                     n.st = S_RD;
                  end else begin
                     n.st = S_WR;
                  end
               end
            end
            S_RD: begin
               if (r.bit_cnt == DATA_LAST) begin
                  n.mdio_oe = 1'b0;
                  n.mdio_o = 1'b0;
                  n.st = S_PRE;
               end else begin
                  n.shift = {r.shift[14:0], 1'b0};
                  n.mdio_o = r.shift[14];
                  n.bit_cnt = 5'(r.bit_cnt + 5'h01);
               end
            end
            S_WR: begin
               n.shift = wr_data;
               n.bit_cnt = 5'(r.bit_cnt + 5'h01);
               if (r.bit_cnt == DATA_LAST) begin
                  n.st = S_PRE;
                  // reserved bits are stored as written; keeping them zero is up to the host
                  if (r.reg_addr == REG_SPECIAL_CONTROL) begin
                     n.ctrl = wr_data; // RULE_05
                  end
                  if (r.reg_addr == REG_LINK_INTERRUPT) begin
                     n.int_en = wr_data[INT_ENABLE_BIT];
                  end
               end
            end
         endcase
      end

      // link change: first cycle after reset only learns the level
      n.primed = 1'b1;
      n.link_prev = LINK_STATUS;
      if (link_change) begin
         n.link_chg = 1'b1; // RULE_15
      end else if (rd18) begin
         n.link_chg = 1'b0; // RULE_16
      end

      // a read clears, an event in the same cycle still counts
      n.fc = rd19 ? CNT_ZERO : r.fc; // RULE_21
      if (FALSE_CARRIER) begin
         n.fc = sat_inc(n.fc); // RULE_18 RULE_20
      end
      n.dc = rd20 ? CNT_ZERO : r.dc; // RULE_21
      if (dc_event) begin
         n.dc = sat_inc(n.dc); // RULE_19 RULE_20
      end
      // one disconnect per run; a good delimiter ends the run
      if (FALSE_CARRIER) begin
         n.fc_run = 1'b1;
         n.dc_done = r.dc_done | dc_event;
      end else if (GOOD_START_STREAM_DELIMITER) begin
         n.fc_run = 1'b0;
         n.dc_done = 1'b0;
      end

      n.irq = n.int_en & n.link_chg; // RULE_14
      n.sd_out = n.ctrl[CTL_FORCE_GOOD_LINK] | SIGNAL_DETECT_IN; // RULE_04
      n.crs_out = ~n.ctrl[CTL_CRS_DISABLE] & FAST_RECEIVE_PATH_CRS_IN; // RULE_06
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         r <= RESET_VAL; // RULE_22
      end else begin
         r <= n;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign MDIO_O = r.mdio_o;
   assign MDIO_OE = r.mdio_oe;
   assign SCRAMBLER_BYPASS = r.ctrl[CTL_SCRAMBLER_BYPASS]; // RULE_01
   assign ENCODER_BYPASS = r.ctrl[CTL_ENCODER_BYPASS]; // RULE_01
   assign FORCE_H_PATTERN = r.ctrl[CTL_FORCE_H_PATTERN]; // RULE_02
   assign FORCE_34_PATTERN = r.ctrl[CTL_FORCE_34_PATTERN]; // RULE_03
   assign SIGNAL_DETECT_OUTPUT = r.sd_out;
   assign FAST_RECEIVE_PATH_CRS = r.crs_out;
   assign AN_LOOPBACK = r.ctrl[CTL_AN_LOOPBACK]; // RULE_07
   assign TX_DRIVER_TRISTATE = r.ctrl[CTL_TX_TRISTATE]; // RULE_08
   assign FORCE_REV_POLARITY = r.ctrl[CTL_FORCE_POLARITY]; // RULE_09
   assign AUTO_POLARITY_DISABLE = r.ctrl[CTL_AUTO_POL_DISABLE]; // RULE_10
   assign SQUELCH_TEST_DISABLE = r.ctrl[CTL_SQUELCH_TEST_DISABLE]; // RULE_11
   assign EXT_SQUELCH_EN = r.ctrl[CTL_EXT_SQUELCH]; // RULE_12
   assign LINK_CHECK_DISABLE = r.ctrl[CTL_LINK_CHECK_DISABLE]; // RULE_13
   assign JABBER_DISABLE = r.ctrl[CTL_JABBER_DISABLE]; // RULE_13
   assign LINK_IRQ = r.irq;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   a_ctrl_write: assert property (wr_done && r.reg_addr == REG_SPECIAL_CONTROL |=> // RULE_01
      SCRAMBLER_BYPASS == $past(wr_data[CTL_SCRAMBLER_BYPASS]) &&
      ENCODER_BYPASS == $past(wr_data[CTL_ENCODER_BYPASS]) &&
      TX_DRIVER_TRISTATE == $past(wr_data[CTL_TX_TRISTATE]) &&
      JABBER_DISABLE == $past(wr_data[CTL_JABBER_DISABLE]))
      else $error("special control write not reflected on outputs");
   a_ctrl_hold: assert property (!(wr_done && r.reg_addr == REG_SPECIAL_CONTROL) |=> $stable(r.ctrl)) // RULE_01
      else $error("special control changed without a write");
   // these outputs register the next control value, so they line up with the register itself
   a_good_link: assert property (r.ctrl[CTL_FORCE_GOOD_LINK] |-> SIGNAL_DETECT_OUTPUT) // RULE_04
      else $error("good link force not on signal detect");
   a_crs_off: assert property (r.ctrl[CTL_CRS_DISABLE] |-> !FAST_RECEIVE_PATH_CRS) // RULE_06
      else $error("carrier sense passed while disabled");
   a_int_en_write: assert property (wr_done && r.reg_addr == REG_LINK_INTERRUPT |=> // RULE_14
      r.int_en == $past(wr_data[INT_ENABLE_BIT]))
      else $error("interrupt enable write not stored");
   a_irq_gate: assert property (!r.int_en |-> !LINK_IRQ) // RULE_14
      else $error("interrupt line driven while disabled");
   a_irq_raise: assert property (link_change && r.int_en && !wr_done |=> LINK_IRQ) // RULE_14
      else $error("interrupt line missing after link change");
   a_link_set: assert property (link_change |=> r.link_chg ##1 (r.link_chg || $past(rd18))) // RULE_15
      else $error("link change not latched");
   a_link_clear: assert property (rd18 && !link_change |=> !r.link_chg) // RULE_16
      else $error("link status not cleared by read");
   a_irq_drop: assert property (rd18 && !link_change |=> !LINK_IRQ) // RULE_16
      else $error("interrupt line stayed up after status read");
   a_int_rsvd: assert property (rd18 |=> r.shift[15:2] == INT_RESERVED_READ) // RULE_17
      else $error("interrupt reserved bits not zero");
   a_fc_count: assert property (FALSE_CARRIER && !rd19 && r.fc != CNT_MAX |=> r.fc == $past(r.fc) + CNT_ONE) // RULE_18
      else $error("false carrier count did not step");
   a_dc_count: assert property (dc_event && !rd20 && r.dc != CNT_MAX |=> r.dc == $past(r.dc) + CNT_ONE) // RULE_19
      else $error("disconnect count did not step");
   a_cnt_sat: assert property (r.fc == CNT_MAX && !rd19 |=> r.fc == CNT_MAX) // RULE_20
      else $error("false carrier count wrapped");
   a_dc_sat: assert property (r.dc == CNT_MAX && !rd20 |=> r.dc == CNT_MAX) // RULE_20
      else $error("disconnect count wrapped");
   a_fc_rdclr: assert property (rd19 && !FALSE_CARRIER |=> r.fc == CNT_ZERO) // RULE_21
      else $error("false carrier count not cleared by read");
   a_dc_rdclr: assert property (rd20 && !dc_event |=> r.dc == CNT_ZERO) // RULE_21
      else $error("disconnect count not cleared by read");
   a_reset_zero: assert property (disable iff (1'b0) !RSTN |=> r.fc == CNT_ZERO && r.dc == CNT_ZERO && !r.link_chg) // RULE_22
      else $error("counters or status not zero after reset");

   c_read_frame: cover property (rd_load ##[1:1000] (r.st == S_PRE));
   c_ctrl_write: cover property (wr_done && r.reg_addr == REG_SPECIAL_CONTROL);
   c_fc_sat: cover property (r.fc == CNT_MAX && FALSE_CARRIER);
   c_irq: cover property ($rose(LINK_IRQ));
   c_dc_step: cover property (dc_event && !rd20);

endmodule

// >>> inc/phy_regs_pkg.sv
package phy_regs_pkg;

   // ***************************************************
   // register addresses on the management serial bus
   // ***************************************************
   localparam logic [4:0] REG_SPECIAL_CONTROL = 5'h11;
   localparam logic [4:0] REG_LINK_INTERRUPT = 5'h12;
   localparam logic [4:0] REG_FALSE_CARRIER_COUNT = 5'h13;
   localparam logic [4:0] REG_DISCONNECT_COUNT = 5'h14;

   // ***************************************************
   // special control field positions
   // ***************************************************
   localparam int CTL_SCRAMBLER_BYPASS = 15;
   localparam int CTL_ENCODER_BYPASS = 14;
   localparam int CTL_FORCE_H_PATTERN = 13;
   localparam int CTL_FORCE_34_PATTERN = 12;
   localparam int CTL_FORCE_GOOD_LINK = 11;
   localparam int CTL_CRS_DISABLE = 9;
   localparam int CTL_AN_LOOPBACK = 7;
   localparam int CTL_TX_TRISTATE = 6;
   localparam int CTL_FORCE_POLARITY = 5;
   localparam int CTL_AUTO_POL_DISABLE = 4;
   localparam int CTL_SQUELCH_TEST_DISABLE = 3;
   localparam int CTL_EXT_SQUELCH = 2;
   localparam int CTL_LINK_CHECK_DISABLE = 1;
   localparam int CTL_JABBER_DISABLE = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ***************************************************
   // link interrupt field positions
   // ***************************************************
   localparam int INT_ENABLE_BIT = 1;
   localparam int INT_LINK_CHANGE_BIT = 0;
   localparam logic [13:0] INT_RESERVED_READ = 14'h0000;

   // ***************************************************
   // counters
   // ***************************************************
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // ***************************************************
   // management frame layout
   // ***************************************************
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [4:0] HDR_LAST = 5'h0c;
   localparam logic [4:0] DATA_LAST = 5'h0f;
   localparam logic [4:0] TA_SECOND = 5'h01;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam int HDR_ST_BIT = 12;
   localparam int HDR_OP_HI = 11;
   localparam int HDR_OP_LO = 10;
   localparam int HDR_PHY_HI = 9;
   localparam int HDR_PHY_LO = 5;
   localparam int HDR_REG_HI = 4;
   localparam int HDR_REG_LO = 0;

   typedef enum logic [2:0] {
      S_PRE,
      S_HDR,
      S_TA,
      S_RD,
      S_WR
   } mdio_state_e;

endpackage

// >>> tb/mdio_station.sv
`timescale 1ns/100ps
module mdio_station (
   input wire logic clk,
   output logic mdc,
   output logic mdio_i,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   // ***************************************************
   // management host, clock stands low between frames
   // ***************************************************
   logic host_oe = 1'b0;
   logic host_bit = 1'b1;

   initial mdc = 1'b0;
   // pull-up: released wire reads high
   assign mdio_i = mdio_oe ? mdio_o : (host_oe ? host_bit : 1'b1);

   task automatic clk_bit(input logic oe, input logic b, output logic smp);
      host_oe = oe;
      host_bit = b;
      repeat (4) @(negedge clk);
      mdc = 1'b1;
      smp = mdio_i;
      repeat (4) @(negedge clk);
      mdc = 1'b0;
   endtask

   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [13:0] hdr;
      logic [15:0] wd;
      logic s;
      hdr = {2'b01, op, phy, rg};
      wd = (rg == 5'h11) ? (wdata & 16'hfaff) : wdata;
      rdata = 16'h0000;
      for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
      if (op == 2'h2) begin
         clk_bit(1'b0, 1'b1, s);
         clk_bit(1'b0, 1'b1, s);
         for (int i = 15; i >= 0; i--) begin
            clk_bit(1'b0, 1'b1, s);
            rdata[i] = s;
         end
         // idle edge; the device already released the wire on the last data edge
         clk_bit(1'b0, 1'b1, s);
      end else begin
         clk_bit(1'b1, 1'b1, s);
         clk_bit(1'b1, 1'b0, s);
         for (int i = 15; i >= 0; i--) clk_bit(1'b1, wd[i], s);
      end
      host_oe = 1'b0;
      // one clock apart so a following frame never retakes the wire in the same step
      @(negedge clk);
   endtask
endmodule

// >>> tb/phy_special_ctrl_intr_counters_test.sv
`timescale 1ns/100ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module phy_special_ctrl_intr_counters_test
   import phy_regs_pkg::*;
();
   // ***************************************************
   // stimulus and checks
   // ***************************************************
   localparam logic [4:0] MY_ADDR = 5'h05;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic lnk = 1'b0, fc = 1'b0, gd = 1'b0, sdi = 1'b0, crsi = 1'b1;
   logic mdc, mdi, mdo, mdoe;
   logic scr, enc, fh, f34, sdo, crs, anl, tri_s, rev, apd, sqt, exs, lcd, jab, irq;
   logic [15:0] ctl_view;
   int fail_count = 0;
   int check_count = 0;

   always #2.5 clk = ~clk;
   // bit 9 is a disable, so carrier sense shows inverted
   assign ctl_view = {scr, enc, fh, f34, sdo, 1'b0, ~crs, 1'b0, anl, tri_s, rev, apd, sqt, exs, lcd, jab};

   phy_special_ctrl_intr_counters dut (.SYS_CLK(clk), .RSTN(rstn), .MDC(mdc), .MDIO_I(mdi), .MDIO_O(mdo),
      .MDIO_OE(mdoe), .PHY_ADDR(MY_ADDR), .LINK_STATUS(lnk), .FALSE_CARRIER(fc),
      .GOOD_START_STREAM_DELIMITER(gd), .SIGNAL_DETECT_IN(sdi), .FAST_RECEIVE_PATH_CRS_IN(crsi),
      .SCRAMBLER_BYPASS(scr), .ENCODER_BYPASS(enc), .FORCE_H_PATTERN(fh), .FORCE_34_PATTERN(f34),
      .SIGNAL_DETECT_OUTPUT(sdo), .FAST_RECEIVE_PATH_CRS(crs), .AN_LOOPBACK(anl),
      .TX_DRIVER_TRISTATE(tri_s), .FORCE_REV_POLARITY(rev), .AUTO_POLARITY_DISABLE(apd),
      .SQUELCH_TEST_DISABLE(sqt), .EXT_SQUELCH_EN(exs), .LINK_CHECK_DISABLE(lcd),
      .JABBER_DISABLE(jab), .LINK_IRQ(irq));

   mdio_station host (.clk(clk), .mdc(mdc), .mdio_i(mdi), .mdio_o(mdo), .mdio_oe(mdoe));

   task automatic wr(input logic [4:0] rg, input logic [15:0] d);
      logic [15:0] unused;
      host.frame(OP_WRITE, MY_ADDR, rg, d, unused);
      repeat (4) @(negedge clk);
   endtask

   task automatic rd(input logic [4:0] rg, output logic [15:0] d);
      host.frame(OP_READ, MY_ADDR, rg, 16'h0000, d);
   endtask

   task automatic pulse(ref logic sig, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         sig = 1'b1;
      end
      @(negedge clk);
      sig = 1'b0;
   endtask

   task automatic check_reset_state;
      logic [15:0] d;
      `CHECK(ctl_view, CTRL_RESET)
      `CHECK(irq, 1'b0)
      for (int r = 17; r <= 20; r++) begin
         rd(r[4:0], d);
         `CHECK(d, 16'h0000)
      end
   endtask

   task automatic check_control_bits;
      logic [15:0] d;
      logic [15:0] m;
      for (int i = 0; i < 16; i++) begin
         m = 16'h0001 << i;
         if (i == 10 || i == 8) continue;
         wr(REG_SPECIAL_CONTROL, m);
         `CHECK(ctl_view[15:8], m[15:8])
         `CHECK(ctl_view[7:0], m[7:0])
      end
      wr(REG_SPECIAL_CONTROL, 16'hffff);
      rd(REG_SPECIAL_CONTROL, d);
      `CHECK(d, 16'hfaff)
      wr(REG_SPECIAL_CONTROL, 16'h0000);
      sdi = 1'b1;
      crsi = 1'b0;
      repeat (3) @(negedge clk);
      `CHECK({sdo, crs}, 2'b10)
      sdi = 1'b0;
      crsi = 1'b1;
   endtask

   task automatic check_link_interrupt;
      logic [15:0] d;
      wr(REG_LINK_INTERRUPT, 16'h0000);
      lnk = ~lnk;
      repeat (3) @(negedge clk);
      `CHECK(irq, 1'b0)
      rd(REG_LINK_INTERRUPT, d);
      `CHECK(d, 16'h0001)
      rd(REG_LINK_INTERRUPT, d);
      `CHECK(d, 16'h0000)
      wr(REG_LINK_INTERRUPT, 16'hffff);
      rd(REG_LINK_INTERRUPT, d);
      `CHECK(d, 16'h0002)
      lnk = ~lnk;
      repeat (3) @(negedge clk);
      `CHECK(irq, 1'b1)
      rd(REG_LINK_INTERRUPT, d);
      `CHECK(d, 16'h0003)
      `CHECK(irq, 1'b0)
      wr(REG_LINK_INTERRUPT, 16'h0000);
   endtask

   task automatic check_counters;
      logic [15:0] d;
      // runs: three back to back, a lone one, then two with a gap
      pulse(fc, 3);
      pulse(gd, 1);
      pulse(fc, 1);
      pulse(gd, 1);
      pulse(fc, 1);
      pulse(fc, 1);
      pulse(gd, 1);
      rd(REG_FALSE_CARRIER_COUNT, d);
      `CHECK(d, 16'h0006)
      rd(REG_DISCONNECT_COUNT, d);
      `CHECK(d, 16'h0002)
      pulse(fc, 1);
      pulse(gd, 1);
      // a frame for another port must not clear anything
      host.frame(OP_READ, MY_ADDR ^ 5'h01, REG_FALSE_CARRIER_COUNT, 16'h0000, d);
      `CHECK(d, 16'hffff)
      rd(REG_FALSE_CARRIER_COUNT, d);
      `CHECK(d, 16'h0001)
      rd(REG_DISCONNECT_COUNT, d);
      `CHECK(d, 16'h0000)
   endtask

   task automatic check_saturation;
      logic [15:0] d;
      pulse(fc, 65536);
      pulse(gd, 1);
      rd(REG_FALSE_CARRIER_COUNT, d);
      `CHECK(d, CNT_MAX)
      rd(REG_FALSE_CARRIER_COUNT, d);
      `CHECK(d, CNT_ZERO)
      rd(REG_DISCONNECT_COUNT, d);
      `CHECK(d, CNT_ONE)
   endtask

   task automatic print_verdict;
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      check_reset_state();
      check_control_bits();
      check_link_interrupt();
      check_counters();
      check_saturation();
      print_verdict();
   end
endmodule
